// ---- hdl/docc_map.vh ----
`ifndef DOCC_MAP_VH
`define DOCC_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define DOCC_A_IDENT      13'h0000
`define DOCC_A_MEMSEL     13'h0001
`define DOCC_A_STRAP      13'h000d
`define DOCC_A_PCLK       13'h0018
`define DOCC_A_CAMCLK     13'h001c
`define DOCC_A_TVDAC      13'h005b
`define DOCC_A_LUTSEL     13'h01e0
`define DOCC_A_MODE       13'h01fc
`define DOCC_A_CAMCMD     13'h1000
`define DOCC_A_GPIOCFG    13'h0004
`define DOCC_A_GPIODAT    13'h0008

// ****************************************
// Field positions
// ****************************************
`define DOCC_B_TVPAL      0
`define DOCC_B_DACLVL     3
`define DOCC_B_LUMA       4
`define DOCC_B_CHROMA     5
`define DOCC_B_DBLCLK     7
`define DOCC_B_LUTSEL     0
`define DOCC_B_CAMPWR     1
`define DOCC_B_CABLE      7
`define DOCC_B_PINTWO     2
`define DOCC_B_STRAP13    5
`define DOCC_B_STRAP14    6
`define DOCC_M_CAMSTRAP   8'h60

// ****************************************
// Display mode encodings
// ****************************************
`define DOCC_MODE_OFF     3'h0
`define DOCC_MODE_CRT     3'h1
`define DOCC_MODE_TV      3'h2
`define DOCC_MODE_TVFF    3'h6

// ****************************************
// Reset values
// ****************************************
`define DOCC_RST_MEMSEL   8'h80
`define DOCC_RST_BYTE     8'h00
`define DOCC_RST_CAMCMD   16'h0000

// ****************************************
// Timing counts
// ****************************************
`define DOCC_STRAP_WAIT   2'h2

`endif

// ---- hdl/docc_lut_mem.v ----
`timescale 1ns/1ps
// Small palette memory, registered read port
module docc_lut_mem #(
   parameter AW = 8,
   parameter DW = 8
) (
   input  wire          sys_clk,
   input  wire          wrEn,
   input  wire [AW-1:0] wrAddr,
   input  wire [DW-1:0] wrData,
   input  wire [AW-1:0] rdAddr,
   output reg  [DW-1:0] rdData
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule // docc_lut_mem

// ---- hdl/docc_display_camera_ctrl.v ----
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "docc_map.vh"
module docc_display_camera_ctrl #(
   parameter [5:0] PRODUCT_CODE = 6'h2a,  // Arbitrary value
   parameter [1:0] REVISION     = 2'h2,   // Arbitrary value
   parameter [3:0] CAM_REV      = 4'h5    // Arbitrary value
) (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire [12:0] regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [15:0] regRdData,
   input  wire        strapDataLine13,
   input  wire        strapDataLine14,
   input  wire        cameraCableAbsent,
   input  wire [7:0]  pixelIn,
   input  wire [7:0]  panelDataIn,
   input  wire [7:0]  cameraDataIn,
   input  wire        lutWrite,
   input  wire [7:0]  lutAddr,
   input  wire [7:0]  lutData,
   input  wire [7:0]  lcdPixel,
   input  wire [7:0]  crtTvPixel,
   output reg  [7:0]  lcdLutOut,
   output reg  [7:0]  crtTvLutOut,
   output reg  [8:0]  dacData,
   output reg         crtEnable,
   output reg         tvEnable,
   output reg         tvPal,
   output reg         flickerFilterOn,
   output reg         chromaFilterOn,
   output reg         lumaFilterOn,
   output reg         doublePixelClock,
   output reg         generalPinTwo,
   output reg         generalPinTwoOe,
   output reg         cameraPortOn,
   output reg  [7:0]  panelDataHigh,
   output reg  [7:0]  cameraDataOut,
   output reg  [7:0]  cameraClockCfg
);

   // ****************************************
   // Strap capture
   // ****************************************
   // Straps are pins: two stages before use
   reg [1:0] strapMeta_q;
   reg [1:0] strapSync_q;
   reg       strapTaken_q;
   reg [1:0] strapWait_q;
   reg [1:0] strapLatched_q;
   reg [1:0] cableSync_q;
   reg [7:0] camMeta_q;
   reg [7:0] camSync_q;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strapMeta_q    <= 2'h0;
         strapSync_q    <= 2'h0;
         cableSync_q    <= 2'h3;
         strapTaken_q   <= 1'b0;
         strapWait_q    <= 2'h0;
         strapLatched_q <= 2'h0;
      end else begin
         strapMeta_q <= {strapDataLine14, strapDataLine13};
         strapSync_q <= strapMeta_q;
         cableSync_q <= {cableSync_q[0], cameraCableAbsent};
         // Taken once the sync stages hold the pins, not their reset zeros
         if (!strapTaken_q) begin
            if (strapWait_q == `DOCC_STRAP_WAIT) begin
               strapTaken_q   <= 1'b1;
               strapLatched_q <= strapSync_q;
            end else begin
               strapWait_q <= strapWait_q + 2'h1;
            end
         end
      end
   end

   // Camera bits synced one by one; a bit may skew by a cycle
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         camMeta_q <= 8'h00;
         camSync_q <= 8'h00;
      end else begin
         camMeta_q <= cameraDataIn;
         camSync_q <= camMeta_q;
      end
   end

   // Holds low until the strap has been caught
   wire camOn = strapTaken_q & strapLatched_q[0] & strapLatched_q[1];

   // ****************************************
   // Register file
   // ****************************************
   reg [7:0]  memSel_q;
   reg [7:0]  pclk_q;
   reg [7:0]  camClk_q;
   reg [7:0]  tvDac_q;
   reg [7:0]  lutSel_q;
   reg [7:0]  mode_q;
   reg [7:0]  gpioCfg_q;
   reg [7:0]  gpioDat_q;
   reg        camPwr_q;

   function isAddr;
      input [12:0] a;
      input [12:0] b;
      begin
         isAddr = (a == b);
      end
   endfunction

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         memSel_q  <= `DOCC_RST_MEMSEL;
         pclk_q    <= `DOCC_RST_BYTE;
         camClk_q  <= `DOCC_RST_BYTE;
         tvDac_q   <= `DOCC_RST_BYTE;
         lutSel_q  <= `DOCC_RST_BYTE;
         mode_q    <= `DOCC_RST_BYTE;
         gpioCfg_q <= `DOCC_RST_BYTE;
         gpioDat_q <= `DOCC_RST_BYTE;
         camPwr_q  <= 1'b0;
      end else if (regWr) begin
         if (isAddr(regAddr, `DOCC_A_MEMSEL)) begin
            memSel_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_PCLK)) begin
            pclk_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_CAMCLK)) begin
            camClk_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_TVDAC)) begin
            tvDac_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_LUTSEL)) begin
            lutSel_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_MODE)) begin
            mode_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_GPIOCFG)) begin
            gpioCfg_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_GPIODAT)) begin
            gpioDat_q <= regWrData[7:0];
         end
         if (isAddr(regAddr, `DOCC_A_CAMCMD)) begin
            camPwr_q <= regWrData[`DOCC_B_CAMPWR];
         end
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   wire [15:0] camCmdView;
   assign camCmdView = {4'h0, CAM_REV, cableSync_q[1], 5'h00, camPwr_q, 1'b0};

   reg [15:0] rdMux;
   always @* begin
      rdMux = 16'h0000;
      case (regAddr)
         // Identity hidden while memory space is selected
         `DOCC_A_IDENT:   rdMux = memSel_q[7] ? 16'h0000 :
                                  {8'h00, PRODUCT_CODE, REVISION};
         `DOCC_A_MEMSEL:  rdMux = {8'h00, memSel_q};
         `DOCC_A_STRAP:   rdMux = {9'h000, strapLatched_q[1], strapLatched_q[0], 5'h00};
         `DOCC_A_PCLK:    rdMux = {8'h00, pclk_q};
         `DOCC_A_CAMCLK:  rdMux = {8'h00, camClk_q};
         `DOCC_A_TVDAC:   rdMux = {8'h00, tvDac_q};
         `DOCC_A_LUTSEL:  rdMux = {8'h00, lutSel_q};
         `DOCC_A_MODE:    rdMux = {8'h00, mode_q};
         `DOCC_A_GPIOCFG: rdMux = {8'h00, gpioCfg_q};
         `DOCC_A_GPIODAT: rdMux = {8'h00, gpioDat_q};
         `DOCC_A_CAMCMD:  rdMux = camCmdView;
         default:         rdMux = 16'h0000;
      endcase
   end

   // ****************************************
   // Output path decode
   // ****************************************
   wire [2:0] modeSel = mode_q[2:0];
   reg        crtSel;
   reg        tvSel;
   reg        ffSel;

   always @* begin
      crtSel = 1'b0;
      tvSel  = 1'b0;
      ffSel  = 1'b0;
      case (modeSel)
         `DOCC_MODE_OFF:  crtSel = 1'b0;
         `DOCC_MODE_CRT:  crtSel = 1'b1;
         `DOCC_MODE_TVFF: begin
            tvSel = 1'b1;
            ffSel = 1'b1;
         end
         default:         tvSel = modeSel[1];
      endcase
   end

   // ****************************************
   // Look-up tables
   // ****************************************
   // Select low: one write lands in both tables
   wire lcdWr = lutWrite;
   wire crtWr = lutWrite & ~lutSel_q[`DOCC_B_LUTSEL];
   wire [7:0] lcdLutRd;
   wire [7:0] crtLutRd;

   // The LCD owns this table; CRT and TV share the other
   docc_lut_mem #(.AW(8), .DW(8)) lcdLut (
      .sys_clk (sys_clk),
      .wrEn    (lcdWr),
      .wrAddr  (lutAddr),
      .wrData  (lutData),
      .rdAddr  (lcdPixel),
      .rdData  (lcdLutRd)
   );

   // With select set, writes only hit the LCD table
   docc_lut_mem #(.AW(8), .DW(8)) crtLut (
      .sys_clk (sys_clk),
      .wrEn    (crtWr),
      .wrAddr  (lutAddr),
      .wrData  (lutData),
      .rdAddr  (crtTvPixel),
      .rdData  (crtLutRd)
   );

   // ****************************************
   // Output registers
   // ****************************************
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData        <= 16'h0000;
         lcdLutOut        <= 8'h00;
         crtTvLutOut      <= 8'h00;
         dacData          <= 9'h000;
         crtEnable        <= 1'b0;
         tvEnable         <= 1'b0;
         tvPal            <= 1'b0;
         flickerFilterOn  <= 1'b0;
         chromaFilterOn   <= 1'b0;
         lumaFilterOn     <= 1'b0;
         doublePixelClock <= 1'b0;
         generalPinTwo    <= 1'b0;
         generalPinTwoOe  <= 1'b0;
         cameraPortOn     <= 1'b0;
         panelDataHigh    <= 8'h00;
         cameraDataOut    <= 8'h00;
         cameraClockCfg   <= 8'h00;
      end else begin
         regRdData   <= regRd ? rdMux : 16'h0000;
         lcdLutOut   <= lcdLutRd;
         crtTvLutOut <= crtLutRd;
         // Never both at once; TV wins an illegal mix
         crtEnable <= crtSel & ~tvSel;
         tvEnable  <= tvSel;
         tvPal     <= tvDac_q[`DOCC_B_TVPAL];
         // Flicker from the TVFF mode decode; chroma and luma each from their own bit
         flickerFilterOn <= ffSel;
         chromaFilterOn  <= tvDac_q[`DOCC_B_CHROMA];
         lumaFilterOn    <= tvDac_q[`DOCC_B_LUMA];
         // Software must set this for flicker mode; not forced here
         doublePixelClock <= pclk_q[`DOCC_B_DBLCLK];
         // Doubled code pairs with a lower reference current
         if (crtSel & ~tvSel & tvDac_q[`DOCC_B_DACLVL]) begin
            dacData <= {pixelIn, 1'b0};
         end else begin
            dacData <= {1'b0, pixelIn};
         end
         cameraPortOn <= camOn;
         if (camOn) begin
            // Pin two carries camera power; ordinary controls ignored
            generalPinTwo   <= camPwr_q;
            generalPinTwoOe <= 1'b1;
            panelDataHigh   <= 8'h00;
            cameraDataOut   <= camSync_q;
         end else begin
            generalPinTwo   <= gpioDat_q[`DOCC_B_PINTWO];
            generalPinTwoOe <= gpioCfg_q[`DOCC_B_PINTWO];
            panelDataHigh   <= panelDataIn;
            cameraDataOut   <= 8'h00;
         end
         cameraClockCfg <= camClk_q;
      end
   end
endmodule // docc_display_camera_ctrl

// ---- tb/docc_chk.sv ----
`timescale 1ns/1ps
`include "docc_map.vh"
module docc_chk #(
   parameter [3:0] CAM_REV = 4'h5
) (
   input wire        sys_clk,
   input wire        rst_n,
   input wire [12:0] regAddr,
   input wire        regRd,
   input wire [15:0] regRdData,
   input wire        strapDataLine13,
   input wire        strapDataLine14,
   input wire        cameraCableAbsent,
   input wire [7:0]  pixelIn,
   input wire [7:0]  panelDataIn,
   input wire [8:0]  dacData,
   input wire        crtEnable,
   input wire        tvEnable,
   input wire        cameraPortOn,
   input wire [7:0]  panelDataHigh
);
   // ****************************************
   // Cycles since reset release
   // ****************************************
   // Strap latch settles on the 3rd edge, the port output on the 4th, so early cycles are skipped
   reg [2:0] rstCnt_q;
   always @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         rstCnt_q <= 3'h0;
      else if (rstCnt_q != 3'h7)
         rstCnt_q <= rstCnt_q + 3'h1;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence strapRead;
      regRd && regAddr == `DOCC_A_STRAP && rstCnt_q > 3'h4;
   endsequence
   sequence cmdRead;
      regRd && regAddr == `DOCC_A_CAMCMD && rstCnt_q > 3'h4;
   endsequence
   sequence cableSteady;
      $stable(cameraCableAbsent) [*4];
   endsequence
   a_crt_tv_excl: assert property (!(crtEnable && tvEnable))
      else $error("crt and tv both on");
   a_port_held: assert property (rstCnt_q > 3'h4 |-> $stable(cameraPortOn))
      else $error("camera port changed");
   a_port_strap: assert property (rstCnt_q > 3'h4 |->
      cameraPortOn == (strapDataLine13 && strapDataLine14)) else $error("port vs straps");
   a_strap_read: assert property (strapRead |=>
      ((regRdData[7:0] & `DOCC_M_CAMSTRAP) == 8'h60) == cameraPortOn) else $error("strap read");
   a_cable_bit: assert property (cableSteady ##0 cmdRead |=>
      regRdData[7] == cameraCableAbsent) else $error("cable bit");
   a_cam_rev: assert property (cmdRead |=> regRdData[11:8] == CAM_REV)
      else $error("camera revision");
   a_dac_plain: assert property (rstCnt_q > 3'h1 && !crtEnable && $past(!crtEnable) |->
      dacData == {1'b0, $past(pixelIn)}) else $error("dac scaled off crt");
   a_panel_free: assert property (rstCnt_q > 3'h4 && !cameraPortOn |->
      panelDataHigh == $past(panelDataIn)) else $error("panel high byte");
   a_panel_taken: assert property (rstCnt_q > 3'h4 && cameraPortOn |->
      panelDataHigh == 8'h00) else $error("panel high byte driven");
endmodule // docc_chk

bind docc_display_camera_ctrl docc_chk #(.CAM_REV(CAM_REV)) uChk (.sys_clk, .rst_n, .regAddr,
   .regRd, .regRdData, .strapDataLine13, .strapDataLine14, .cameraCableAbsent, .pixelIn,
   .panelDataIn, .dacData, .crtEnable, .tvEnable, .cameraPortOn, .panelDataHigh);

// ---- tb/docc_cam_model.sv ----
`timescale 1ns/1ps
module docc_cam_model (
   input  wire       sys_clk,
   input  wire       attached,
   input  wire       powerPin,
   input  wire       powerOe,
   output wire       cableAbsent,
   output reg  [7:0] camData
);
   // ****************************************
   // Camera behaviour
   // ****************************************
   assign cableAbsent = !attached;
   initial camData = 8'h5a;
   // Unpowered lines float, so they toggle instead of holding
   always @(posedge sys_clk)
      camData <= (attached && powerPin && powerOe) ? camData + 8'h01 : ~camData;
endmodule // docc_cam_model

// ---- tb/docc_display_output_camera_port_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`include "docc_map.vh"
module docc_display_output_camera_port_ctrl_tb_top;
   localparam [5:0] PC = 6'h2d; // Arbitrary value
   localparam [1:0] RV = 2'h3;  // Arbitrary value
   localparam [3:0] CR = 4'h9;  // Arbitrary value
   reg sys_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, lutWrite = 1'b0;
   reg strapDataLine13 = 1'b1, strapDataLine14 = 1'b1, attached = 1'b1;
   reg [12:0] regAddr = 13'h0;
   reg [15:0] regWrData = 16'h0;
   reg [7:0] pixelIn = 8'h0, panelDataIn = 8'h0, lutAddr = 8'h0, lutData = 8'h0;
   reg [7:0] lcdPixel = 8'h0, crtTvPixel = 8'h0, p;
   reg [31:0] r;
   reg [2:0] m;
   integer i, numErrors = 0, comparisons = 0;
   wire [15:0] regRdData;
   wire [8:0] dacData;
   wire [7:0] cameraDataIn, lcdLutOut, crtTvLutOut, panelDataHigh, cameraClockCfg, cameraDataOut;
   wire cameraCableAbsent, crtEnable, tvEnable, flickerFilterOn, chromaFilterOn, lumaFilterOn;
   wire doublePixelClock, generalPinTwo, generalPinTwoOe, cameraPortOn, tvPal;
   docc_display_camera_ctrl #(.PRODUCT_CODE(PC), .REVISION(RV), .CAM_REV(CR)) DUT (.sys_clk,
      .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .strapDataLine13,
      .strapDataLine14, .cameraCableAbsent, .pixelIn, .panelDataIn, .cameraDataIn, .lutWrite,
      .lutAddr, .lutData, .lcdPixel, .crtTvPixel, .lcdLutOut, .crtTvLutOut, .dacData,
      .crtEnable, .tvEnable, .tvPal, .flickerFilterOn, .chromaFilterOn, .lumaFilterOn,
      .doublePixelClock, .generalPinTwo, .generalPinTwoOe, .cameraPortOn, .panelDataHigh,
      .cameraDataOut, .cameraClockCfg);
   docc_cam_model uCam (.sys_clk, .attached, .powerPin(generalPinTwo), .powerOe(generalPinTwoOe),
      .cableAbsent(cameraCableAbsent), .camData(cameraDataIn));
   // ****************************************
   // Bus and check tasks
   // ****************************************
   initial forever #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) panelDataIn <= 8'($urandom);
   task chk(input [15:0] got, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            numErrors = numErrors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Waits two edges past the write so the output flops have caught up
   task wr(input [12:0] a, input [15:0] v);
      begin
         @(posedge sys_clk);
         regWr <= 1'b1;
         regAddr <= a;
         regWrData <= v;
         @(posedge sys_clk);
         regWr <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1;
      end
   endtask
   task rc(input [12:0] a, input [15:0] mask, input [15:0] exp);
      begin
         @(posedge sys_clk);
         regRd <= 1'b1;
         regAddr <= a;
         @(posedge sys_clk);
         regRd <= 1'b0;
         #1;
         chk(regRdData & mask, exp);
      end
   endtask
   task lutw(input [7:0] a, input [7:0] v);
      begin
         @(posedge sys_clk);
         lutWrite <= 1'b1;
         lutAddr <= a;
         lutData <= v;
         @(posedge sys_clk);
         lutWrite <= 1'b0;
         lcdPixel <= a;
         crtTvPixel <= a;
         repeat (3) @(posedge sys_clk);
         #1;
      end
   endtask
   task doReset(input s14);
      begin
         @(posedge sys_clk);
         rst_n <= 1'b0;
         strapDataLine14 <= s14;
         repeat (6) @(posedge sys_clk);
         rst_n <= 1'b1;
         repeat (6) @(posedge sys_clk);
         #1;
      end
   endtask
   task printVerdict;
      begin
         $display("counts: %0d compares, %0d mismatches", comparisons, numErrors);
         if (numErrors == 0 && comparisons > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      #3000000;
      numErrors = numErrors + 1;
      printVerdict;
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      r = $urandom(48);
      doReset(1'b1);
      chk(16'(cameraPortOn), 16'h1);
      rc(`DOCC_A_STRAP, 16'h0060, 16'h0060);
      rc(`DOCC_A_IDENT, 16'hffff, 16'h0);
      wr(`DOCC_A_MEMSEL, 16'h0);
      wr(`DOCC_A_IDENT, 16'hffff);
      rc(`DOCC_A_IDENT, 16'hffff, 16'({PC, RV}));
      rc(13'h0123, 16'hffff, 16'h0);
      rc(`DOCC_A_CAMCMD, 16'h0f80, 16'({CR, 8'h00}));
      @(posedge sys_clk) attached <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rc(`DOCC_A_CAMCMD, 16'h0f80, 16'({CR, 8'h80}));
      $display("test ident done");
      wr(`DOCC_A_CAMCMD, 16'h0002);
      wr(`DOCC_A_GPIODAT, 16'h0);
      wr(`DOCC_A_GPIOCFG, 16'h0);
      chk(16'({generalPinTwoOe, generalPinTwo}), 16'h3);
      wr(`DOCC_A_GPIODAT, 16'h0004);
      wr(`DOCC_A_CAMCMD, 16'h0);
      chk(16'({generalPinTwoOe, generalPinTwo}), 16'h2);
      p = cameraDataIn;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(16'({panelDataHigh, cameraDataOut}), 16'(p));
      $display("test power done");
      for (i = 0; i < 8; i = i + 1) begin
         m = 3'(i);
         wr(`DOCC_A_MODE, 16'(m));
         chk(16'({crtEnable, tvEnable, flickerFilterOn}), 16'({m == 1, m[1], m == 6}));
      end
      for (i = 0; i < 8; i = i + 1) begin
         r = $urandom;
         m = r[6] ? 3'h6 : 3'h2;
         wr(`DOCC_A_TVDAC, 16'(r & 32'h31));
         wr(`DOCC_A_MODE, 16'(m));
         wr(`DOCC_A_PCLK, 16'({m == 6, 7'h0}));
         chk(16'({flickerFilterOn, chromaFilterOn, lumaFilterOn, doublePixelClock, tvPal}),
            16'({m == 6, r[5], r[4], m == 6, r[0]}));
      end
      $display("test modes done");
      wr(`DOCC_A_TVDAC, 16'h0008);
      wr(`DOCC_A_MODE, 16'h0);
      wr(`DOCC_A_MODE, 16'h1);
      for (i = 0; i < 5; i = i + 1) begin
         if (i == 4)
            wr(`DOCC_A_MODE, 16'h2);
         p = (i == 0) ? 8'hff : 8'($urandom);
         @(posedge sys_clk) pixelIn <= p;
         @(posedge sys_clk) #1;
         chk(16'(dacData), (i == 4) ? 16'(p) : 16'({p, 1'b0}));
      end
      r = $urandom;
      wr(`DOCC_A_CAMCLK, 16'(r[7:0]));
      chk(16'(cameraClockCfg), 16'(r[7:0]));
      $display("test dac done");
      wr(`DOCC_A_LUTSEL, 16'h0);
      lutw(8'h3c, 8'ha5);
      chk({lcdLutOut, crtTvLutOut}, 16'ha5a5);
      wr(`DOCC_A_LUTSEL, 16'h1);
      lutw(8'h3c, 8'h5e);
      chk({lcdLutOut, crtTvLutOut}, 16'h5ea5);
      $display("test lut done");
      doReset(1'b0);
      chk(16'({cameraPortOn, cameraDataOut}), 16'h0);
      rc(`DOCC_A_STRAP, 16'h0060, 16'h0020);
      $display("test strap done");
      printVerdict;
   end
endmodule // docc_display_output_camera_port_ctrl_tb_top
